// *** hdl/usw_params.svh ***
`ifndef USW_PARAMS_SVH
`define USW_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define USW_OFS_SETUP0   8'h00
`define USW_OFS_SETUP1   8'h04
`define USW_OFS_SETUP2   8'h08
`define USW_OFS_CTRL     8'h0C
`define USW_OFS_STATUS   8'h10
`define USW_OFS_IRQ_STS  8'h14
`define USW_OFS_IRQ_MASK 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USW_SETUP0_SS_BIT   0
`define USW_SETUP0_SYNC_BIT 1
`define USW_CTRL_CD_LSB     0
`define USW_CTRL_ADV_LSB    2
`define USW_CTRL_FB_BIT     4
`define USW_STS_MODE_LSB    0
`define USW_STS_WARN_BIT    2
`define USW_STS_ADV_LSB     3
`define USW_STS_PA_BIT      5
`define USW_STS_PB_BIT      6
`define USW_IRQ_WARN_BIT    0
`define USW_IRQ_MODE_BIT    1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define USW_RST_SETUP0   2'h0
`define USW_RST_GAIN     5'h00
`define USW_RST_DC_CURRENT_LIMIT_SEL     3'h0
`define USW_RST_CD       2'h0
`define USW_RST_ADV      2'h0
`define USW_RST_FB       1'b0
`define USW_RST_IRQ_MASK 2'h0

// ----------------------------------------------------------------
// Advertisement codes and strap current limit codes
// ----------------------------------------------------------------
`define USW_ADV_0A5      2'h0
`define USW_ADV_1A5      2'h1
`define USW_ADV_3A0      2'h2
`define USW_DC_CURRENT_LIMIT_SEL_STRAP0  3'h1
`define USW_DC_CURRENT_LIMIT_SEL_STRAP1  3'h4
`define USW_DC_CURRENT_LIMIT_SEL_STRAP2  3'h6
`define USW_DC_CURRENT_LIMIT_SEL_STRAP3  3'h7

`endif

// *** hdl/usw_pkg.sv ***
package usw_pkg;

   typedef enum logic [1:0] {
      USW_MODE_OFF,
      USW_MODE_INVALID,
      USW_MODE_SDP,
      USW_MODE_CDP
   } usw_mode_t;

   // Resistor strap steps, already digitised to 0..15
   typedef struct packed {
      logic [3:0] pin_a;
      logic [3:0] pin_b;
      logic [3:0] pin_c;
   } usw_strap_t;

endpackage : usw_pkg

// *** hdl/usw_top.sv ***
`timescale 1ns/1ns

`include "usw_params.svh"

// ----------------------------------------------------------------
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
// ----------------------------------------------------------------
module usw_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q, s2_q, s3_q;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         q_o <= '0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_o <= s3_q;
         end
      end
   end
endmodule : usw_sync

module usw_top #(
   parameter int STRAP_VARIANT = 0
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Device pins
   input wire logic switch_master_enable_i,
   input wire logic logic_supply_good_i,
   input wire logic charger_mode_pin_i,
   input wire logic cdp_port_flag_i,
   input wire logic temp_warn_cross_i,
   input wire usw_pkg::usw_strap_t strap_i,
   // Data switches and mode
   output logic path_a_switch_o,
   output logic path_b_switch_o,
   output usw_pkg::usw_mode_t switch_mode_o,
   // Thermal and configuration outputs
   output logic thermal_warning_flag_o,
   output logic [1:0] source_current_advert_o,
   output logic [2:0] dc_current_limit_sel_o,
   output logic [4:0] cable_comp_sel_o,
   output logic spread_spec_en_o,
   output logic sync_dir_in_o,
   // Interrupt
   output logic irq_o
);
   import usw_pkg::*;

   if (STRAP_VARIANT != 0 && STRAP_VARIANT != 1) begin : g_chk
      $error("STRAP_VARIANT must be 0 or 1");
   end

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic en_s, sup_s, bcm_s, cdp_s, warn_s;
   logic [11:0] strap_raw;
   usw_strap_t strap_s;

   usw_sync #(.W(5)) u_sync_pins (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .d_i({switch_master_enable_i, logic_supply_good_i, charger_mode_pin_i,
            cdp_port_flag_i, temp_warn_cross_i}),
      .q_o({en_s, sup_s, bcm_s, cdp_s, warn_s})
   );

   usw_sync #(.W(12)) u_sync_strap (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .d_i(strap_i),
      .q_o(strap_raw)
   );
   assign strap_s = usw_strap_t'(strap_raw);

   // ----------------------------------------------------------------
   // Configuration registers and bus slave
   // ----------------------------------------------------------------
   logic en_prev_q, preload, fb_en_q, accept, wr_pend_q, rd_irq_clr;
   logic [1:0] setup0_q, cd_q, adv_q, irq_sts_q, irq_mask_q, irq_ev, strap_adv;
   logic [2:0] dc_current_limit_sel_q, strap_dc_current_limit_sel;
   logic [4:0] gain_q;
   logic [7:0] addr_q;
   logic [31:0] rd_data;
   logic wr_setup0, wr_setup1, wr_setup2, wr_ctrl, wr_mask;

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_s;
      end
   end
   assign preload = en_s & ~en_prev_q;

   // Subset of limit and advertisement codes reachable by strap
   always_comb begin
      case (strap_s.pin_c[1:0])
         2'h0: begin
            strap_dc_current_limit_sel = `USW_DC_CURRENT_LIMIT_SEL_STRAP0;
            strap_adv = `USW_ADV_0A5;
         end
         2'h1: begin
            strap_dc_current_limit_sel = `USW_DC_CURRENT_LIMIT_SEL_STRAP1;
            strap_adv = `USW_ADV_1A5;
         end
         2'h2: begin
            strap_dc_current_limit_sel = `USW_DC_CURRENT_LIMIT_SEL_STRAP2;
            strap_adv = `USW_ADV_1A5;
         end
         default: begin
            strap_dc_current_limit_sel = `USW_DC_CURRENT_LIMIT_SEL_STRAP3;
            strap_adv = `USW_ADV_3A0;
         end
      endcase
   end

   assign accept = hsel_i & hready_i & htrans_i[1];
   assign rd_irq_clr = accept & ~hwrite_i & (haddr_i[7:0] == `USW_OFS_IRQ_STS);
   assign wr_setup0 = wr_pend_q & (addr_q == `USW_OFS_SETUP0);
   assign wr_setup1 = wr_pend_q & (addr_q == `USW_OFS_SETUP1);
   assign wr_setup2 = wr_pend_q & (addr_q == `USW_OFS_SETUP2);
   assign wr_ctrl = wr_pend_q & (addr_q == `USW_OFS_CTRL);
   assign wr_mask = wr_pend_q & (addr_q == `USW_OFS_IRQ_MASK);

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         wr_pend_q <= accept & hwrite_i & (hsize_i == 3'h2);
         if (accept) begin
            addr_q <= haddr_i[7:0];
         end
         hrdata_o <= (accept & ~hwrite_i) ? rd_data : 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   // Preload wins over a write landing in the same cycle
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         setup0_q <= `USW_RST_SETUP0;
         gain_q <= `USW_RST_GAIN;
         dc_current_limit_sel_q <= `USW_RST_DC_CURRENT_LIMIT_SEL;
         cd_q <= `USW_RST_CD;
         adv_q <= `USW_RST_ADV;
         fb_en_q <= `USW_RST_FB;
         irq_mask_q <= `USW_RST_IRQ_MASK;
      end else begin
         if (preload) begin
            setup0_q[`USW_SETUP0_SS_BIT] <= ~strap_s.pin_a[3];
            setup0_q[`USW_SETUP0_SYNC_BIT] <= ~strap_s.pin_a[2];
         end else if (wr_setup0) begin
            setup0_q <= hwdata_i[1:0];
         end
         if (preload && STRAP_VARIANT == 1) begin
            gain_q <= {strap_s.pin_c[2], strap_s.pin_b};
            dc_current_limit_sel_q <= strap_dc_current_limit_sel;
            adv_q <= strap_adv;
            fb_en_q <= ~strap_s.pin_c[3];
         end else begin
            if (wr_setup1) begin
               gain_q <= hwdata_i[4:0];
            end
            if (wr_setup2) begin
               dc_current_limit_sel_q <= hwdata_i[2:0];
            end
            if (wr_ctrl) begin
               adv_q <= hwdata_i[`USW_CTRL_ADV_LSB +: 2];
               fb_en_q <= hwdata_i[`USW_CTRL_FB_BIT];
            end
         end
         if (wr_ctrl) begin
            cd_q <= hwdata_i[`USW_CTRL_CD_LSB +: 2];
         end
         if (wr_mask) begin
            irq_mask_q <= hwdata_i[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Data switch mode decode
   // ----------------------------------------------------------------
   usw_mode_t mode_d;
   logic pa_d, pb_d;

   // Strap variant decodes pins only; variant 0 also decodes cd_q, so a role swap needs no bus access only while cd_q is 0
   always_comb begin
      mode_d = USW_MODE_OFF;
      if (!en_s) begin
         mode_d = USW_MODE_OFF;
      end else if (!sup_s) begin
         mode_d = USW_MODE_INVALID;
      end else if (STRAP_VARIANT == 1) begin
         mode_d = bcm_s ? USW_MODE_CDP : USW_MODE_SDP;
      end else if (bcm_s || cd_q == 2'h1) begin
         mode_d = USW_MODE_CDP;
      end else if (cd_q == 2'h0) begin
         mode_d = USW_MODE_SDP;
      end else begin
         mode_d = USW_MODE_INVALID;
      end
      case (mode_d)
         USW_MODE_SDP: begin
            pa_d = 1'b1;
            pb_d = 1'b0;
         end
         USW_MODE_CDP: begin
            pa_d = ~cdp_s;
            pb_d = cdp_s;
         end
         default: begin
            pa_d = 1'b0;
            pb_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         switch_mode_o <= USW_MODE_OFF;
         path_a_switch_o <= 1'b0;
         path_b_switch_o <= 1'b0;
      end else begin
         switch_mode_o <= mode_d;
         path_a_switch_o <= pa_d;
         path_b_switch_o <= pb_d;
      end
   end

   // ----------------------------------------------------------------
   // Thermal warning and foldback
   // ----------------------------------------------------------------
   logic [1:0] adv_d;

   always_comb begin
      adv_d = adv_q;
      if (fb_en_q && thermal_warning_flag_o && adv_q != `USW_ADV_0A5) begin
         adv_d = adv_q - 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         thermal_warning_flag_o <= 1'b0;
         source_current_advert_o <= `USW_RST_ADV;
      end else begin
         thermal_warning_flag_o <= warn_s;
         source_current_advert_o <= adv_d;
      end
   end

   // Foldback never reaches these: limit, gain, switch mode stay put
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dc_current_limit_sel_o <= `USW_RST_DC_CURRENT_LIMIT_SEL;
         cable_comp_sel_o <= `USW_RST_GAIN;
         spread_spec_en_o <= 1'b0;
         sync_dir_in_o <= 1'b0;
      end else begin
         dc_current_limit_sel_o <= dc_current_limit_sel_q;
         cable_comp_sel_o <= gain_q;
         spread_spec_en_o <= setup0_q[`USW_SETUP0_SS_BIT];
         sync_dir_in_o <= setup0_q[`USW_SETUP0_SYNC_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Interrupts; an event in the clearing read cycle is kept
   // ----------------------------------------------------------------
   assign irq_ev[`USW_IRQ_WARN_BIT] = warn_s & ~thermal_warning_flag_o;
   assign irq_ev[`USW_IRQ_MODE_BIT] = (mode_d != switch_mode_o);

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_sts_q <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         irq_sts_q <= (irq_sts_q & ~{2{rd_irq_clr}}) | irq_ev;
         irq_o <= |(irq_sts_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      case (haddr_i[7:0])
         `USW_OFS_SETUP0: rd_data[1:0] = setup0_q;
         `USW_OFS_SETUP1: rd_data[4:0] = gain_q;
         `USW_OFS_SETUP2: rd_data[2:0] = dc_current_limit_sel_q;
         `USW_OFS_CTRL: begin
            rd_data[`USW_CTRL_CD_LSB +: 2] = cd_q;
            rd_data[`USW_CTRL_ADV_LSB +: 2] = adv_q;
            rd_data[`USW_CTRL_FB_BIT] = fb_en_q;
         end
         `USW_OFS_STATUS: begin
            rd_data[`USW_STS_MODE_LSB +: 2] = switch_mode_o;
            rd_data[`USW_STS_WARN_BIT] = thermal_warning_flag_o;
            rd_data[`USW_STS_ADV_LSB +: 2] = source_current_advert_o;
            rd_data[`USW_STS_PA_BIT] = path_a_switch_o;
            rd_data[`USW_STS_PB_BIT] = path_b_switch_o;
         end
         `USW_OFS_IRQ_STS: rd_data[1:0] = irq_sts_q;
         `USW_OFS_IRQ_MASK: rd_data[1:0] = irq_mask_q;
         default: rd_data = 32'h0000_0000;
      endcase
   end

endmodule : usw_top

// *** verif/usw_top_monitor.sv ***
`timescale 1ns/1ns
// ------------------------------------------------
// Switch mode and foldback port checks
// ------------------------------------------------
module usw_top_monitor
   import usw_pkg::*;
(
   // Clock, reset and pins
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic switch_master_enable_i,
   input wire logic logic_supply_good_i,
   input wire logic temp_warn_cross_i,
   // Outputs watched
   input wire logic path_a_switch_o,
   input wire logic path_b_switch_o,
   input wire usw_mode_t switch_mode_o,
   input wire logic thermal_warning_flag_o,
   input wire logic [2:0] dc_current_limit_sel_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);

   a_off_open: assert property (switch_mode_o == USW_MODE_OFF |->
      !path_a_switch_o && !path_b_switch_o) else $error("switch closed while off");
   a_inval_open: assert property (switch_mode_o == USW_MODE_INVALID |->
      !path_a_switch_o && !path_b_switch_o) else $error("switch closed while invalid");
   a_sdp_paths: assert property (switch_mode_o == USW_MODE_SDP |->
      path_a_switch_o && !path_b_switch_o) else $error("wrong paths in pass-through");
   a_cdp_one_path: assert property (switch_mode_o == USW_MODE_CDP |->
      path_a_switch_o != path_b_switch_o) else $error("not one path in charging");
   // Eight cycles covers the synchroniser plus output flop
   a_en_low_off: assert property (!switch_master_enable_i [*8] |->
      switch_mode_o == USW_MODE_OFF) else $error("mode not off with enable low");
   a_no_supply: assert property ((switch_master_enable_i && !logic_supply_good_i) [*8]
      |-> switch_mode_o == USW_MODE_INVALID) else $error("mode not invalid");
   a_warn_set: assert property (temp_warn_cross_i [*8] |-> thermal_warning_flag_o)
      else $error("warning flag missing");
   a_warn_clear: assert property (!temp_warn_cross_i [*8] |-> !thermal_warning_flag_o)
      else $error("warning flag stuck");
   a_fold_keeps: assert property ($changed(thermal_warning_flag_o) |->
      $stable(dc_current_limit_sel_o) && $stable(switch_mode_o))
      else $error("foldback disturbed limit or mode");
endmodule : usw_top_monitor

bind usw_top usw_top_monitor u_mon (
   .ref_clk_i(ref_clk_i),
   .rstn_i(rstn_i),
   .switch_master_enable_i(switch_master_enable_i),
   .logic_supply_good_i(logic_supply_good_i),
   .temp_warn_cross_i(temp_warn_cross_i),
   .path_a_switch_o(path_a_switch_o),
   .path_b_switch_o(path_b_switch_o),
   .switch_mode_o(switch_mode_o),
   .thermal_warning_flag_o(thermal_warning_flag_o),
   .dc_current_limit_sel_o(dc_current_limit_sel_o)
);

// *** verif/usw_usb_peer.sv ***
`timescale 1ns/1ns
// ------------------------------------------------
// Far side: controller and attached device
// ------------------------------------------------
module usw_usb_peer (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Requests from the bench
   input wire logic swap_req_i,
   input wire logic mode_req_i,
   input wire logic attach_i,
   // Pins toward the switch block
   output logic charger_mode_o,
   output logic cdp_port_flag_o
);
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         charger_mode_o <= 1'b0;
         cdp_port_flag_o <= 1'b0;
      end else begin
         // Unnegotiated swap pending: charger mode pin held low; pass-through only in the strap variant or while cd_q is 0
         charger_mode_o <= mode_req_i && !swap_req_i;
         cdp_port_flag_o <= attach_i;
      end
   end
endmodule : usw_usb_peer

// *** verif/tb.sv ***
`timescale 1ns/1ns
`include "usw_params.svh"
module tb;
   import usw_pkg::*;
   logic ref_clk, rstn, hsel, hwrite, en, sup, temp, swap, mreq, att, bc, flg;
   logic hready, hresp, hr_smp, pa, pb, warn, ssen, sdir, irq, fb;
   logic [1:0] htrans, adv, s;
   logic [2:0] dc_current_limit_sel;
   logic [3:0] v;
   logic [4:0] gain, c;
   logic [31:0] haddr, hwdata, hrdata, rd_smp, rv, d;
   usw_strap_t strap;
   usw_mode_t mode, m0, m, mode2, m2;
   logic pa2, pb2;
   logic [1:0] adv2;
   logic [2:0] ilim2;
   logic [4:0] gain2, xs;
   logic [31:0] hrdata2, rd_smp2;
   int errors, check_count, seed;

   usw_top #(.STRAP_VARIANT(0)) DUT (
      .ref_clk_i(ref_clk), .rstn_i(rstn),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .switch_master_enable_i(en), .logic_supply_good_i(sup),
      .charger_mode_pin_i(bc), .cdp_port_flag_i(flg),
      .temp_warn_cross_i(temp), .strap_i(strap),
      .path_a_switch_o(pa), .path_b_switch_o(pb), .switch_mode_o(mode),
      .thermal_warning_flag_o(warn), .source_current_advert_o(adv),
      .dc_current_limit_sel_o(dc_current_limit_sel), .cable_comp_sel_o(gain),
      .spread_spec_en_o(ssen), .sync_dir_in_o(sdir), .irq_o(irq));

   usw_usb_peer PEER (.ref_clk_i(ref_clk), .rstn_i(rstn), .swap_req_i(swap),
      .mode_req_i(mreq), .attach_i(att), .charger_mode_o(bc), .cdp_port_flag_o(flg));

   // Strap variant shares pins and bus; hready comes from the first slave
   usw_top #(.STRAP_VARIANT(1)) DUT2 (
      .ref_clk_i(ref_clk), .rstn_i(rstn),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata2), .hreadyout_o(), .hresp_o(),
      .switch_master_enable_i(en), .logic_supply_good_i(sup),
      .charger_mode_pin_i(bc), .cdp_port_flag_i(flg),
      .temp_warn_cross_i(temp), .strap_i(strap),
      .path_a_switch_o(pa2), .path_b_switch_o(pb2), .switch_mode_o(mode2),
      .thermal_warning_flag_o(), .source_current_advert_o(adv2),
      .dc_current_limit_sel_o(ilim2), .cable_comp_sel_o(gain2),
      .spread_spec_en_o(), .sync_dir_in_o(), .irq_o());

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Edge samples avoid racing the bus outputs
   always @(posedge ref_clk) begin
      rd_smp <= hrdata;
      hr_smp <= hready;
      rd_smp2 <= hrdata2;
   end

   task automatic conclude;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic hwait;
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         #1;
         i++;
      end while (hr_smp !== 1'b1 && i < 50);
      if (i >= 50) begin
         errors++;
         conclude();
      end
   endtask : hwait

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hwait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      hwait();
      r = rd_smp;
   endtask : bus

   task automatic settle;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : settle

   function automatic usw_mode_t exp_mode(logic e, logic p, logic b, logic [1:0] cd, logic sv);
      if (!e) return USW_MODE_OFF;
      if (!p) return USW_MODE_INVALID;
      if (sv) return b ? USW_MODE_CDP : USW_MODE_SDP;
      if (b || cd == 2'h1) return USW_MODE_CDP;
      return (cd == 2'h0) ? USW_MODE_SDP : USW_MODE_INVALID;
   endfunction : exp_mode

   function automatic logic [1:0] exp_paths(usw_mode_t md, logic f);
      if (md == USW_MODE_SDP) return 2'b10;
      return (md == USW_MODE_CDP) ? {~f, f} : 2'b00;
   endfunction : exp_paths

   // Strap step low bits pick limit and advertisement together
   function automatic logic [4:0] exp_strap(logic [1:0] st);
      case (st)
         2'h0: return {`USW_DC_CURRENT_LIMIT_SEL_STRAP0, `USW_ADV_0A5};
         2'h1: return {`USW_DC_CURRENT_LIMIT_SEL_STRAP1, `USW_ADV_1A5};
         2'h2: return {`USW_DC_CURRENT_LIMIT_SEL_STRAP2, `USW_ADV_1A5};
         default: return {`USW_DC_CURRENT_LIMIT_SEL_STRAP3, `USW_ADV_3A0};
      endcase
   endfunction : exp_strap

   initial begin
      {rstn, hsel, hwrite, en, sup, temp, swap, mreq, att} = '0;
      htrans = 2'h0;
      haddr = '0;
      hwdata = '0;
      strap = '0;
      errors = 0;
      check_count = 0;
      seed = $urandom(97);
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      #1;
      // ------------------------------------------------
      // Reset values, unmapped word at 0x1C
      // ------------------------------------------------
      for (int a = 0; a <= 28; a += 4) begin
         bus(1'b0, 8'(a), 32'h0, rv);
         chk("reset word", rv, 32'h0);
         chk("response", {hresp, hready}, 32'h1);
      end
      // ------------------------------------------------
      // Preload on enable rise, then overwrite
      // ------------------------------------------------
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
         en <= 1'b0;
         settle();
         strap <= {v, 8'($urandom)};
         en <= 1'b1;
         sup <= 1'b1;
         settle();
         chk("preload", {ssen, sdir}, {30'h0, ~v[3], ~v[2]});
         chk("startup mode", {mode, mode2}, {USW_MODE_SDP, USW_MODE_SDP});
         xs = exp_strap(strap.pin_c[1:0]);
         chk("strap gain", gain2, {strap.pin_c[2], strap.pin_b});
         chk("strap limit", {ilim2, adv2}, xs);
         bus(1'b0, `USW_OFS_CTRL, 32'h0, rv);
         chk("strap ctrl", rd_smp2, {27'h0, ~strap.pin_c[3], xs[1:0], 2'h0});
         d = $urandom;
         bus(1'b1, `USW_OFS_SETUP0, d, rv);
         bus(1'b0, `USW_OFS_SETUP0, 32'h0, rv);
         chk("setup0", rv, d & 32'h3);
         bus(1'b1, `USW_OFS_SETUP2, d, rv);
         bus(1'b0, `USW_OFS_SETUP2, 32'h0, rv);
         chk("limit", rv, d & 32'h7);
         chk("limit out", {dc_current_limit_sel, ilim2}, {2{d[2:0]}});
         bus(1'b1, `USW_OFS_SETUP1, d, rv);
         bus(1'b0, `USW_OFS_SETUP1, 32'h0, rv);
         chk("gain", rv, d & 32'h1F);
         chk("gain out", {gain, gain2}, {2{d[4:0]}});
      end
      // ------------------------------------------------
      // Every enable, supply, select and mode pin case
      // ------------------------------------------------
      for (int k = 0; k < 32; k++) begin
         c = 5'(k);
         bus(1'b1, `USW_OFS_CTRL, {30'h0, c[2:1]}, rv);
         {en, sup, mreq} <= {c[4], c[3], c[0]};
         att <= 1'($urandom);
         settle();
         m = exp_mode(c[4], c[3], c[0], c[2:1], 1'b0);
         m2 = exp_mode(c[4], c[3], c[0], c[2:1], 1'b1);
         chk("mode", mode, m);
         chk("paths", {pa, pb}, exp_paths(m, att));
         chk("strap mode", {mode2, pa2, pb2}, {m2, exp_paths(m2, att)});
      end
      // Unnegotiated swap: controller holds pass-through
      bus(1'b1, `USW_OFS_CTRL, 32'h0, rv);
      {en, sup, mreq, swap} <= 4'hF;
      settle();
      chk("swap mode", {mode, mode2}, {USW_MODE_SDP, USW_MODE_SDP});
      swap <= 1'b0;
      mreq <= 1'b0;
      // ------------------------------------------------
      // Foldback per advertisement, last pass disabled
      // ------------------------------------------------
      bus(1'b1, `USW_OFS_IRQ_MASK, 32'h1, rv);
      for (int k = 0; k < 4; k++) begin
         fb = (k != 3);
         s = (k == 3) ? 2'h2 : 2'(k);
         bus(1'b1, `USW_OFS_SETUP2, $urandom, rv);
         bus(1'b1, `USW_OFS_CTRL, {27'h0, fb, s, 2'h0}, rv);
         settle();
         bus(1'b0, `USW_OFS_IRQ_STS, 32'h0, rv);
         settle();
         m0 = mode;
         v = {1'b0, dc_current_limit_sel};
         temp <= 1'b1;
         settle();
         chk("warn", {warn, irq}, 2'b11);
         chk("advert", adv, (fb && s != 2'h0) ? s - 2'h1 : s);
         chk("kept", {mode, dc_current_limit_sel}, {m0, v[2:0]});
         bus(1'b0, `USW_OFS_IRQ_STS, 32'h0, rv);
         chk("warn status", rv[0], 1'b1);
         temp <= 1'b0;
         settle();
         chk("restore", {warn, irq, adv}, {2'b00, s});
      end
      conclude();
   end

   initial begin
      #200000;
      errors++;
      conclude();
   end
endmodule : tb
